// >>> core/pmg_dcnt.v
// loadable down-counter with a done flag
`timescale 1ns/10ps
`default_nettype none

module pmg_dcnt #(
  parameter W = 32
) (
  input wire clk,
  input wire rst_n,
  input wire load,
  input wire [W-1:0] load_val,
  output wire done
);

  reg [W-1:0] cnt_q;

  // a load of n holds the caller n cycles, never less than one
  assign done = (cnt_q[W-1:1] == {(W-1){1'b0}});

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {W{1'b0}};
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule // pmg_dcnt

`default_nettype wire

// >>> core/pmg_list.v
// train list storage with fill count
`timescale 1ns/10ps
`default_nettype none
`include "pmg_consts.vh"

module pmg_list #(
  parameter W = 18
) (
  input wire clk,
  input wire rst_n,
  input wire clear,
  input wire wr,
  input wire [W-1:0] wdata,
  input wire [`PMG_IDX_W-1:0] rd_idx,
  output wire [W-1:0] rd_data,
  output reg [`PMG_IDX_W-1:0] count_q
);

  localparam integer DEPTH_I = `PMG_LIST_DEPTH;
  localparam [`PMG_IDX_W-1:0] DEPTH = DEPTH_I[`PMG_IDX_W-1:0];

  reg [W-1:0] mem_q [0:`PMG_LIST_DEPTH-1];
  wire [`PMG_IDX_W-1:0] wr_idx;
  wire wr_ok;

  // a clear in the same cycle restarts the fill at entry zero
  assign wr_idx = clear ? {`PMG_IDX_W{1'b0}} : count_q;
  assign wr_ok = wr && (clear || (count_q < DEPTH));
  assign rd_data = mem_q[rd_idx];

  // contents carry no reset and survive it
  always @(posedge clk) begin
    if (wr_ok) begin
      mem_q[wr_idx] <= wdata;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= {`PMG_IDX_W{1'b0}};
    end else if (clear) begin
      count_q <= wr ? {{(`PMG_IDX_W-1){1'b0}}, 1'b1} : {`PMG_IDX_W{1'b0}};
    end else if (wr_ok) begin
      count_q <= count_q + {{(`PMG_IDX_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // pmg_list

`default_nettype wire

// >>> core/pmg_top.v
// pulse modulation generator: timing, trigger, train and outputs
`timescale 1ns/10ps
`default_nettype none
`include "pmg_consts.vh"

module pmg_top (
  input wire clk,
  input wire rst_n,
  input wire pulse_mod,
  input wire ext_src_sel,
  input wire mod_pol_inv,
  input wire [1:0] pulse_mode,
  input wire dbl_en,
  input wire [1:0] trig_mode,
  input wire trig_slope_neg,
  input wire gate_pol_inv,
  input wire single_trig,
  input wire sync_en,
  input wire [`PMG_TIME_W-1:0] dly_cyc,
  input wire [`PMG_TIME_W-1:0] width_cyc,
  input wire [`PMG_TIME_W-1:0] period_cyc,
  input wire [`PMG_TIME_W-1:0] dbl_dly_cyc,
  input wire [`PMG_TIME_W-1:0] dbl_wid_cyc,
  input wire [1:0] list_sel,
  input wire list_clear,
  input wire list_wr,
  input wire [`PMG_ENTRY_W-1:0] list_wdata,
  input wire ext_pulse_input,
  input wire ext_modulation_input,
  input wire rf_settling,
  output reg rf_mod_q,
  output reg pulse_video_q,
  output reg sync_valid_q,
  output wire [`PMG_IDX_W-1:0] on_count,
  output wire [`PMG_IDX_W-1:0] off_count,
  output wire [`PMG_IDX_W-1:0] rep_count,
  output wire busy
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_DLY = 9'h002;
  localparam [8:0] ST_ON1 = 9'h004;
  localparam [8:0] ST_GAP = 9'h008;
  localparam [8:0] ST_ON2 = 9'h010;
  localparam [8:0] ST_REST = 9'h020;
  localparam [8:0] ST_TSEL = 9'h040;
  localparam [8:0] ST_TON = 9'h080;
  localparam [8:0] ST_TOFF = 9'h100;

  localparam integer TRAIN_MAX_I = `PMG_TRAIN_MAX_CYC;
  localparam [`PMG_ENTRY_W-1:0] TRAIN_MAX = TRAIN_MAX_I[`PMG_ENTRY_W-1:0];
  localparam [`PMG_IDX_W-1:0] IDX_ONE = 11'h001;
  localparam [`PMG_REP_W-1:0] REP_ONE = 16'h0001;

  reg [8:0] st_q;
  reg [8:0] st_d;
  reg [`PMG_IDX_W-1:0] idx_q;
  reg [`PMG_IDX_W-1:0] idx_d;
  reg [`PMG_REP_W-1:0] rcnt_q;
  reg [`PMG_REP_W-1:0] rcnt_d;
  reg played_q;
  reg played_d;
  reg ext_prev_q;
  reg ext_seen_q;
  reg pc_ld;
  reg ph_ld;
  reg dc_ld;
  reg [`PMG_TIME_W-1:0] ph_val;
  reg launch;
  reg adv;
  reg sync_pulse;

  // ----------------------------------------------------------------
  // list storage
  // ----------------------------------------------------------------
  wire [`PMG_ENTRY_W-1:0] clamped;
  wire [`PMG_ENTRY_W-1:0] on_rd;
  wire [`PMG_ENTRY_W-1:0] off_rd;
  wire [`PMG_REP_W-1:0] rep_rd;
  wire [`PMG_IDX_W-1:0] pairs;
  wire [`PMG_IDX_W-1:0] pairs_ab;
  wire last_idx;

  // on and off entries held to the 5 ms ceiling
  assign clamped = (list_wdata > TRAIN_MAX) ? TRAIN_MAX : list_wdata;

  // clear then refill replaces a list
  pmg_list #(.W(`PMG_ENTRY_W)) u_on_list (
    .clk(clk),
    .rst_n(rst_n),
    .clear(list_clear && (list_sel == `PMG_LIST_ON)),
    .wr(list_wr && (list_sel == `PMG_LIST_ON)),
    .wdata(clamped),
    .rd_idx(idx_q),
    .rd_data(on_rd),
    .count_q(on_count)
  );

  pmg_list #(.W(`PMG_ENTRY_W)) u_off_list (
    .clk(clk),
    .rst_n(rst_n),
    .clear(list_clear && (list_sel == `PMG_LIST_OFF)),
    .wr(list_wr && (list_sel == `PMG_LIST_OFF)),
    .wdata(clamped),
    .rd_idx(idx_q),
    .rd_data(off_rd),
    .count_q(off_count)
  );

  pmg_list #(.W(`PMG_REP_W)) u_rep_list (
    .clk(clk),
    .rst_n(rst_n),
    .clear(list_clear && (list_sel == `PMG_LIST_REP)),
    .wr(list_wr && (list_sel == `PMG_LIST_REP)),
    .wdata(list_wdata[`PMG_REP_W-1:0]),
    .rd_idx(idx_q),
    .rd_data(rep_rd),
    .count_q(rep_count)
  );

  // only complete triples of on, off and count are played
  assign pairs_ab = (on_count < off_count) ? on_count : off_count;
  assign pairs = (pairs_ab < rep_count) ? pairs_ab : rep_count;
  assign last_idx = (idx_q == (pairs - IDX_ONE));

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  wire pc_done;
  wire ph_done;
  wire dc_done;

  pmg_dcnt #(.W(`PMG_TIME_W)) u_period (
    .clk(clk),
    .rst_n(rst_n),
    .load(pc_ld),
    .load_val(period_cyc),
    .done(pc_done)
  );

  pmg_dcnt #(.W(`PMG_TIME_W)) u_phase (
    .clk(clk),
    .rst_n(rst_n),
    .load(ph_ld),
    .load_val(ph_val),
    .done(ph_done)
  );

  pmg_dcnt #(.W(`PMG_TIME_W)) u_dbl (
    .clk(clk),
    .rst_n(rst_n),
    .load(dc_ld),
    .load_val(dbl_dly_cyc),
    .done(dc_done)
  );

  // ----------------------------------------------------------------
  // trigger decode
  // ----------------------------------------------------------------
  wire is_train;
  wire is_dbl;
  wire ext_edge;
  wire gate_act;
  wire start_evt;
  wire keep_run;
  wire abort;

  assign is_train = (pulse_mode == `PMG_MODE_TRAIN);
  // double from mode or separate enable, never in train mode
  assign is_dbl = !is_train && ((pulse_mode == `PMG_MODE_DOUBLE) || dbl_en);
  // selected edge, armed one sample after reset
  assign ext_edge = ext_seen_q &&
                    (trig_slope_neg ? (ext_prev_q && !ext_pulse_input)
                                    : (!ext_prev_q && ext_pulse_input));
  assign gate_act = ext_pulse_input ^ gate_pol_inv;
  // four trigger modes; external input as trigger
  assign start_evt = pulse_mod && (
      (trig_mode == `PMG_TRIG_AUTO) ||
      ((trig_mode == `PMG_TRIG_EXT) && ext_edge) ||
      ((trig_mode == `PMG_TRIG_GATE) && gate_act) ||
      ((trig_mode == `PMG_TRIG_SINGLE) && single_trig));
  assign keep_run = (trig_mode == `PMG_TRIG_AUTO) ||
                    ((trig_mode == `PMG_TRIG_GATE) && gate_act);
  // gate loss stops generation at once
  assign abort = !pulse_mod || ((trig_mode == `PMG_TRIG_GATE) && !gate_act);
  assign busy = (st_q != ST_IDLE);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @* begin
    st_d = st_q;
    idx_d = idx_q;
    rcnt_d = rcnt_q;
    played_d = played_q;
    pc_ld = 1'b0;
    ph_ld = 1'b0;
    dc_ld = 1'b0;
    ph_val = {`PMG_TIME_W{1'b0}};
    launch = 1'b0;
    adv = 1'b0;
    sync_pulse = 1'b0;
    case (st_q)
      ST_IDLE: begin
        launch = start_evt;
      end
      ST_DLY: begin
        if (ph_done) begin
          if (is_train) begin
            idx_d = {`PMG_IDX_W{1'b0}};
            played_d = 1'b0;
            st_d = ST_TSEL;
          end else begin
            ph_ld = 1'b1;
            ph_val = width_cyc;
            st_d = ST_ON1;
          end
        end
      end
      ST_ON1: begin
        // second start counts from first start, even mid-pulse
        if (is_dbl && dc_done) begin
          ph_ld = 1'b1;
          ph_val = dbl_wid_cyc;
          st_d = ST_ON2;
        end else if (ph_done) begin
          st_d = is_dbl ? ST_GAP : ST_REST;
        end
      end
      ST_GAP: begin
        if (dc_done) begin
          ph_ld = 1'b1;
          ph_val = dbl_wid_cyc;
          st_d = ST_ON2;
        end
      end
      ST_ON2: begin
        if (ph_done) begin
          st_d = ST_REST;
        end
      end
      ST_REST: begin
        if (pc_done) begin
          if (keep_run) begin
            launch = 1'b1;
          end else begin
            st_d = ST_IDLE;
          end
        end
      end
      ST_TSEL: begin
        if (pairs == {`PMG_IDX_W{1'b0}}) begin
          st_d = ST_IDLE;
        end else if (rep_rd == {`PMG_REP_W{1'b0}}) begin
          adv = 1'b1;
        end else begin
          ph_ld = 1'b1;
          ph_val = {{(`PMG_TIME_W-`PMG_ENTRY_W){1'b0}}, on_rd};
          rcnt_d = rep_rd;
          played_d = 1'b1;
          st_d = ST_TON;
        end
      end
      ST_TON: begin
        if (ph_done) begin
          ph_ld = 1'b1;
          ph_val = {{(`PMG_TIME_W-`PMG_ENTRY_W){1'b0}}, off_rd};
          st_d = ST_TOFF;
        end
      end
      ST_TOFF: begin
        if (ph_done) begin
          // repeat the pair its programmed count
          if (rcnt_q > REP_ONE) begin
            rcnt_d = rcnt_q - REP_ONE;
            ph_ld = 1'b1;
            ph_val = {{(`PMG_TIME_W-`PMG_ENTRY_W){1'b0}}, on_rd};
            st_d = ST_TON;
          end else begin
            adv = 1'b1;
          end
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase

    if (adv) begin
      if (last_idx) begin
        idx_d = {`PMG_IDX_W{1'b0}};
        played_d = 1'b0;
        if (keep_run && played_q) begin
          sync_pulse = 1'b1;
          st_d = ST_TSEL;
        end else begin
          st_d = ST_IDLE;
        end
      end else begin
        idx_d = idx_q + IDX_ONE;
        st_d = ST_TSEL;
      end
    end

    if (launch) begin
      pc_ld = 1'b1;
      ph_ld = 1'b1;
      sync_pulse = 1'b1;
      if (is_dbl) begin
        // no trigger delay in double mode
        ph_val = width_cyc;
        dc_ld = 1'b1;
        st_d = ST_ON1;
      end else begin
        ph_val = dly_cyc;
        st_d = ST_DLY;
      end
    end

    if (abort) begin
      st_d = ST_IDLE;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      idx_q <= {`PMG_IDX_W{1'b0}};
      rcnt_q <= {`PMG_REP_W{1'b0}};
      played_q <= 1'b0;
      ext_prev_q <= 1'b0;
      ext_seen_q <= 1'b0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      rcnt_q <= rcnt_d;
      played_q <= played_d;
      ext_prev_q <= ext_pulse_input;
      ext_seen_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  wire pulse_int;
  wire mod_src;

  assign pulse_int = (st_q == ST_ON1) || (st_q == ST_ON2) || (st_q == ST_TON);
  assign mod_src = ext_src_sel ? ext_modulation_input : pulse_int;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rf_mod_q <= 1'b0;
      pulse_video_q <= 1'b0;
      sync_valid_q <= 1'b0;
    end else begin
      // polarity only on the external source; enable gates it
      rf_mod_q <= pulse_mod && (ext_src_sel ? (mod_src ^ mod_pol_inv)
                                            : mod_src);
      // modulation signal on the video output
      pulse_video_q <= pulse_mod && mod_src;
      // sync pulse per sequence; settling flag otherwise
      sync_valid_q <= sync_en ? sync_pulse : rf_settling;
    end
  end

endmodule // pmg_top

`default_nettype wire

// >>> shared/pmg_consts.vh
// constants for the pulse modulation generator
`ifndef PMG_CONSTS_VH
`define PMG_CONSTS_VH

// ----------------------------------------------------------------
// timing base
// ----------------------------------------------------------------
`define PMG_CLK_NS 25
`define PMG_TIME_W 32

// ----------------------------------------------------------------
// pulse modes
// ----------------------------------------------------------------
`define PMG_MODE_SINGLE 2'h0
`define PMG_MODE_DOUBLE 2'h1
`define PMG_MODE_TRAIN 2'h2

// ----------------------------------------------------------------
// trigger modes
// ----------------------------------------------------------------
`define PMG_TRIG_AUTO 2'h0
`define PMG_TRIG_EXT 2'h1
`define PMG_TRIG_GATE 2'h2
`define PMG_TRIG_SINGLE 2'h3

// ----------------------------------------------------------------
// train lists
// ----------------------------------------------------------------
`define PMG_LIST_DEPTH 2047
`define PMG_IDX_W 11
`define PMG_ENTRY_W 18
`define PMG_REP_W 16
`define PMG_LIST_ON 2'h0
`define PMG_LIST_OFF 2'h1
`define PMG_LIST_REP 2'h2
`define PMG_TRAIN_MAX_NS 5000000
`define PMG_TRAIN_MAX_CYC (`PMG_TRAIN_MAX_NS / `PMG_CLK_NS)

// ----------------------------------------------------------------
// software defaults, in cycles (least times round up)
// ----------------------------------------------------------------
`define PMG_DLY_DEF_NS 10
`define PMG_DLY_DEF_CYC ((`PMG_DLY_DEF_NS + `PMG_CLK_NS - 1) / `PMG_CLK_NS)
`define PMG_DBL_DEF_NS 3000
`define PMG_DBL_DEF_CYC ((`PMG_DBL_DEF_NS + `PMG_CLK_NS - 1) / `PMG_CLK_NS)
`define PMG_PER_DEF_NS 10000
`define PMG_PER_DEF_CYC ((`PMG_PER_DEF_NS + `PMG_CLK_NS - 1) / `PMG_CLK_NS)

`endif

// >>> sim/pmg_chk.sv
// port checker for the pulse modulation generator
`timescale 1ns/10ps
`default_nettype none
`include "pmg_consts.vh"
module pmg_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pulse_mod,
  input wire logic ext_src_sel,
  input wire logic mod_pol_inv,
  input wire logic [1:0] pulse_mode,
  input wire logic dbl_en,
  input wire logic sync_en,
  input wire logic [`PMG_TIME_W-1:0] dly_cyc,
  input wire logic [`PMG_TIME_W-1:0] width_cyc,
  input wire logic [`PMG_TIME_W-1:0] dbl_dly_cyc,
  input wire logic [`PMG_TIME_W-1:0] dbl_wid_cyc,
  input wire logic [1:0] list_sel,
  input wire logic list_clear,
  input wire logic list_wr,
  input wire logic ext_modulation_input,
  input wire logic rf_settling,
  input wire logic rf_mod_q,
  input wire logic pulse_video_q,
  input wire logic sync_valid_q,
  input wire logic [`PMG_IDX_W-1:0] on_count,
  input wire logic [`PMG_IDX_W-1:0] off_count
);
  logic [31:0] since_q;
  logic [31:0] hi_q;
  wire dbl_w = pulse_mode == `PMG_MODE_DOUBLE ||
    (dbl_en && pulse_mode != `PMG_MODE_TRAIN);
  wire sgl_w = !dbl_w && pulse_mode != `PMG_MODE_TRAIN;
  wire int_w = sync_en && !ext_src_sel;
  // cycles since the last sync pulse, length of the rf pulse
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_q <= 32'h0;
      hi_q <= 32'h0;
    end else begin
      since_q <= sync_valid_q ? 32'h1 : since_q + 32'h1;
      hi_q <= rf_mod_q ? hi_q + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rst_quiet_a: assert property ($rose(rst_n) |-> !rf_mod_q &&
    !sync_valid_q && on_count == 0) else $error("outputs not quiet");
  idle_dark_a: assert property (!pulse_mod [*3] |->
    !rf_mod_q && !pulse_video_q) else $error("output while disabled");
  sync_pulse_a: assert property (sync_en && $past(sync_en) &&
    sync_valid_q |=> !sync_valid_q || !sync_en) else $error("long sync");
  settle_path_a: assert property (!sync_en && !$past(sync_en) &&
    pulse_mod && $past(pulse_mod) |-> sync_valid_q == $past(rf_settling))
    else $error("settling not shown");
  ext_pol_a: assert property (pulse_mod && ext_src_sel &&
    $past(pulse_mod) && $past(ext_src_sel) |-> rf_mod_q ==
    ($past(ext_modulation_input) ^ $past(mod_pol_inv))) else $error("pol");
  video_src_a: assert property (pulse_mod && ext_src_sel &&
    $past(pulse_mod) && $past(ext_src_sel) |->
    pulse_video_q == $past(ext_modulation_input)) else $error("video");
  dly_start_a: assert property (int_w && sgl_w && $rose(rf_mod_q)
    |-> since_q == dly_cyc + 1) else $error("pulse delay wrong");
  width_len_a: assert property (int_w && sgl_w && $fell(rf_mod_q)
    |-> hi_q == width_cyc) else $error("pulse width wrong");
  dbl_start_a: assert property (int_w && dbl_w && $rose(rf_mod_q)
    |-> since_q == 1 || since_q == dbl_dly_cyc + 1) else $error("dbl start");
  dbl_width_a: assert property (int_w && dbl_w && $fell(rf_mod_q)
    |-> hi_q == width_cyc || hi_q == dbl_wid_cyc) else $error("dbl width");
  clr_count_a: assert property (list_clear && !list_wr &&
    list_sel == `PMG_LIST_ON |=> on_count == 0) else $error("clear");
  fill_count_a: assert property (list_wr && !list_clear &&
    list_sel == `PMG_LIST_OFF && off_count < 11'h7FF |=>
    off_count == $past(off_count) + 11'h001) else $error("fill count");
endmodule // pmg_chk
bind pmg_top pmg_chk u_chk (.clk(clk), .rst_n(rst_n), .pulse_mod(pulse_mod),
  .ext_src_sel(ext_src_sel), .mod_pol_inv(mod_pol_inv),
  .pulse_mode(pulse_mode), .dbl_en(dbl_en), .sync_en(sync_en),
  .dly_cyc(dly_cyc), .width_cyc(width_cyc), .dbl_dly_cyc(dbl_dly_cyc),
  .dbl_wid_cyc(dbl_wid_cyc), .list_sel(list_sel), .list_clear(list_clear),
  .list_wr(list_wr), .ext_modulation_input(ext_modulation_input),
  .rf_settling(rf_settling), .rf_mod_q(rf_mod_q),
  .pulse_video_q(pulse_video_q), .sync_valid_q(sync_valid_q),
  .on_count(on_count), .off_count(off_count));
`default_nettype wire

// >>> sim/pmg_far.sv
// far-side model: trigger, modulation source, RF modulator
`timescale 1ns/10ps
`default_nettype none
module pmg_far (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic gate_on,
  input wire logic mod_on,
  input wire logic cnt_clr,
  input wire logic rf_mod_q,
  input wire logic sync_valid_q,
  output wire logic ext_pulse_input,
  output wire logic ext_modulation_input,
  output wire logic rf_settling,
  output var int rf_rises,
  output var int syncs
);
  logic [2:0] fire_q;
  logic [7:0] pat_q;
  logic [1:0] set_q;
  logic rf_q;
  logic sy_q;
  // trigger pulse is three cycles wide, so both slopes occur
  assign ext_pulse_input = gate_on | fire_q[0];
  assign ext_modulation_input = mod_on & pat_q[0];
  assign rf_settling = set_q != 2'h0;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fire_q <= 3'h0;
      pat_q <= 8'hB4;
      set_q <= 2'h0;
      rf_q <= 1'h0;
      sy_q <= 1'h0;
      rf_rises <= 0;
      syncs <= 0;
    end else begin
      fire_q <= #1 fire ? 3'h7 : {1'h0, fire_q[2:1]};
      pat_q <= #1 {pat_q[6:0], pat_q[7]};
      // modulator settles for three cycles after each switch
      set_q <= #1 (rf_mod_q != rf_q) ? 2'h3 :
        (set_q == 2'h0) ? 2'h0 : set_q - 2'h1;
      rf_q <= rf_mod_q;
      sy_q <= sync_valid_q;
      if (cnt_clr) begin
        rf_rises <= 0;
        syncs <= 0;
      end else begin
        if (rf_mod_q && !rf_q) rf_rises <= rf_rises + 1;
        if (sync_valid_q && !sy_q) syncs <= syncs + 1;
      end
    end
  end
endmodule // pmg_far
`default_nettype wire

// >>> sim/pmg_top_test.sv
// self-checking bench for the pulse modulation generator
`timescale 1ns/10ps
`default_nettype none
`include "pmg_consts.vh"
module pmg_top_test;
  logic clk, rst_n, pulse_mod, ext_src_sel, mod_pol_inv, dbl_en, sync_en;
  logic trig_slope_neg, gate_pol_inv, single_trig, list_clear, list_wr;
  logic fire, gate_on, mod_on, cnt_clr, prev;
  logic [1:0] pulse_mode, trig_mode, list_sel;
  logic [31:0] dly_cyc, width_cyc, period_cyc, dbl_dly_cyc, dbl_wid_cyc;
  logic [`PMG_ENTRY_W-1:0] list_wdata;
  wire logic ext_pulse_input, ext_modulation_input, rf_settling, busy;
  wire logic rf_mod_q, pulse_video_q, sync_valid_q;
  wire logic [`PMG_IDX_W-1:0] on_count, off_count, rep_count;
  int rf_rises, syncs, i, t, tt[2];
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  // mode, dbl_en, delay, width, dbl delay, dbl width, period, pulses
  int rows[4][8] = '{'{0, 0, 1, 2, 4, 1, 20, 1}, '{0, 0, 5, 3, 4, 1, 40, 1},
    '{1, 0, 7, 2, 6, 3, 30, 2}, '{0, 1, 3, 1, 4, 1, 20, 2}};
  int wl[6] = '{3, 2, 2, 4, 2, 0};
  pmg_top dut (.clk(clk), .rst_n(rst_n), .pulse_mod(pulse_mod),
    .ext_src_sel(ext_src_sel), .mod_pol_inv(mod_pol_inv),
    .pulse_mode(pulse_mode), .dbl_en(dbl_en), .trig_mode(trig_mode),
    .trig_slope_neg(trig_slope_neg), .gate_pol_inv(gate_pol_inv),
    .single_trig(single_trig), .sync_en(sync_en), .dly_cyc(dly_cyc),
    .width_cyc(width_cyc), .period_cyc(period_cyc),
    .dbl_dly_cyc(dbl_dly_cyc), .dbl_wid_cyc(dbl_wid_cyc),
    .list_sel(list_sel), .list_clear(list_clear), .list_wr(list_wr),
    .list_wdata(list_wdata), .ext_pulse_input(ext_pulse_input),
    .ext_modulation_input(ext_modulation_input), .rf_settling(rf_settling),
    .rf_mod_q(rf_mod_q), .pulse_video_q(pulse_video_q),
    .sync_valid_q(sync_valid_q), .on_count(on_count),
    .off_count(off_count), .rep_count(rep_count), .busy(busy));
  pmg_far u_far (.clk(clk), .rst_n(rst_n), .fire(fire), .gate_on(gate_on),
    .mod_on(mod_on), .cnt_clr(cnt_clr), .rf_mod_q(rf_mod_q),
    .sync_valid_q(sync_valid_q), .ext_pulse_input(ext_pulse_input),
    .ext_modulation_input(ext_modulation_input), .rf_settling(rf_settling),
    .rf_rises(rf_rises), .syncs(syncs));
  always #12.5 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chkv(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic done(input string nm);
    $display("test %s finished, mismatches so far %0d", nm, n_errors);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic clrc;
    cnt_clr = 1'h1;
    cyc(1);
    cnt_clr = 1'h0;
  endtask
  task automatic run(input int n);
    clrc;
    pulse_mod = 1'h1;
    cyc(n);
    pulse_mod = 1'h0;
    cyc(10);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test;
    end
  end
  initial begin
    {clk, rst_n, pulse_mod, ext_src_sel, mod_pol_inv, dbl_en, sync_en} = '0;
    {trig_slope_neg, gate_pol_inv, single_trig, list_clear, list_wr} = '0;
    {fire, gate_on, mod_on, cnt_clr, pulse_mode, trig_mode, list_sel} = '0;
    {dly_cyc, width_cyc, period_cyc, dbl_dly_cyc, dbl_wid_cyc} = '0;
    list_wdata = '0;
    repeat (12) @(posedge clk);
    #2 rst_n = 1'h1;
    chk1("rf_mod_q", 1'h0, rf_mod_q);
    chkv("on_count", 0, on_count);
    chkv("off_count", 0, off_count);
    done("reset");
    sync_en = 1'h1;
    foreach (rows[r]) begin
      pulse_mode = rows[r][0][1:0];
      dbl_en = rows[r][1][0];
      dly_cyc = rows[r][2];
      width_cyc = rows[r][3];
      dbl_dly_cyc = rows[r][4];
      dbl_wid_cyc = rows[r][5];
      period_cyc = rows[r][6];
      run(rows[r][6] * 7 / 2);
      chkv("syncs", 4, syncs);
      chkv("rf_rises", 4 * rows[r][7], rf_rises);
    end
    done("table");
    ext_src_sel = 1'h1;
    mod_on = 1'h1;
    pulse_mod = 1'h1;
    for (i = 0; i < 2; i++) begin
      mod_pol_inv = i[0];
      cyc(3);
      prev = ext_modulation_input;
      repeat (8) begin
        cyc(1);
        chk1("rf_mod_q", prev ^ i[0], rf_mod_q);
        chk1("pulse_video_q", prev, pulse_video_q);
        prev = ext_modulation_input;
      end
    end
    sync_en = 1'h0;
    cyc(2);
    prev = rf_settling;
    repeat (12) begin
      cyc(1);
      chk1("sync_valid_q", prev, sync_valid_q);
      prev = rf_settling;
    end
    {pulse_mod, mod_on, ext_src_sel, dbl_en} = '0;
    sync_en = 1'h1;
    {dly_cyc, width_cyc, period_cyc} = {32'h2, 32'h2, 32'h14};
    trig_mode = `PMG_TRIG_EXT;
    cyc(5);
    done("external source");
    for (i = 0; i < 2; i++) begin
      trig_slope_neg = i[0];
      clrc;
      pulse_mod = 1'h1;
      cyc(3);
      fire = 1'h1;
      cyc(1);
      fire = 1'h0;
      for (t = 0; t < 40 && sync_valid_q !== 1'h1; t++) cyc(1);
      tt[i] = t;
      cyc(40);
      chkv("syncs", 1, syncs);
      pulse_mod = 1'h0;
      cyc(2);
    end
    chkv("slope_lag", 3, tt[1] - tt[0]);
    trig_mode = `PMG_TRIG_GATE;
    for (i = 0; i < 2; i++) begin
      gate_pol_inv = i[0];
      gate_on = i[0];
      pulse_mod = 1'h1;
      clrc;
      gate_on = !i[0];
      cyc(70);
      gate_on = i[0];
      cyc(5);
      chk1("rf_mod_q", 1'h0, rf_mod_q);
      chkv("syncs", 4, syncs);
      pulse_mod = 1'h0;
      cyc(2);
    end
    trig_mode = `PMG_TRIG_SINGLE;
    clrc;
    pulse_mod = 1'h1;
    cyc(2);
    single_trig = 1'h1;
    cyc(1);
    single_trig = 1'h0;
    chk1("busy", 1'h1, busy);
    cyc(60);
    chkv("syncs", 1, syncs);
    chk1("busy", 1'h0, busy);
    pulse_mod = 1'h0;
    trig_mode = `PMG_TRIG_AUTO;
    done("triggers");
    list_clear = 1'h1;
    for (i = 0; i < 3; i++) begin
      list_sel = i[1:0];
      cyc(1);
    end
    list_clear = 1'h0;
    list_wr = 1'h1;
    for (i = 0; i < 6; i++) begin
      list_sel = 2'(i / 2);
      list_wdata = 18'(wl[i]);
      cyc(1);
    end
    list_wr = 1'h0;
    cyc(1);
    chkv("on_count", 2, on_count);
    chkv("rep_count", 2, rep_count);
    pulse_mode = `PMG_MODE_TRAIN;
    dly_cyc = 32'h1;
    run(100);
    chk1("train_pairs", 1'h1,
      rf_rises >= 2 * syncs - 2 && rf_rises <= 2 * syncs);
    chk1("train_wrap", 1'h1, syncs > 2);
    list_sel = `PMG_LIST_REP;
    list_clear = 1'h1;
    cyc(1);
    list_clear = 1'h0;
    list_wr = 1'h1;
    cyc(2048);
    list_wr = 1'h0;
    cyc(1);
    chkv("rep_count", 2047, rep_count);
    done("train lists");
    pulse_mode = `PMG_MODE_SINGLE;
    pulse_mod = 1'h1;
    cyc(5);
    rst_n = 1'h0;
    cyc(1);
    chkv("rep_count", 0, rep_count);
    chk1("sync_valid_q", 1'h0, sync_valid_q);
    rst_n = 1'h1;
    cyc(2);
    done("mid-run reset");
    stop_test;
  end
endmodule // pmg_top_test
`default_nettype wire
